// *** logic/rsc_reset_source_controller.sv ***
`timescale 1ns/1ps
module rsc_reset_source_controller #(
  parameter int HOLD_CYCLES = rsc_pkg::HOLD_CYC
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  input wire logic rst_pin_n_in,
  output logic rst_pin_out,
  output logic rst_pin_oe,
  input wire logic supply_above,
  input wire logic comp_out,
  input wire logic system_clock_level,
  input wire logic wdog_expire,
  input wire logic wdog_disable,
  input wire logic flash_rd,
  input wire logic flash_wr,
  input wire logic flash_erase,
  input wire logic table_read,
  input wire logic addr_reserved,
  input wire logic branch_reserved,
  input wire logic security_block,
  output logic sys_reset,
  output logic supply_monitor_enable,
  output logic threshold_select,
  output logic wdog_enable,
  output logic wdog_tick
);
  // ****************************************
  // Declarations
  // ****************************************
  localparam int HCW = $clog2(HOLD_CYCLES + 1);
  // Sequencer state
  rsc_pkg::rsc_state_e state_q;
  rsc_pkg::rsc_state_e state_d;
  // Quiet cycles counted in reset
  logic [HCW-1:0] hold_q;
  logic [HCW-1:0] hold_d;
  // Causes gathered during this reset
  logic [rsc_pkg::SRC_W-1:0] cause_q;
  logic [rsc_pkg::SRC_W-1:0] cause_d;
  // Flags of the last reset, read by software
  logic [rsc_pkg::SRC_W-1:0] flags_q;
  // Supply monitor controls
  logic supply_en_q;
  logic supply_sel_q;
  logic thresh_q;
  // Missing clock and comparator enables
  logic mclk_en_q;
  logic comp_en_q;
  // Watchdog enable and divider
  logic wdog_en_q;
  logic [rsc_pkg::WDOG_CW-1:0] wdog_div_q;
  // Registered read data
  logic [7:0] rdata_q;
  // Request vector, one bit per source
  logic [rsc_pkg::SRC_W-1:0] req;
  // Link to the missing clock detector
  rsc_mclk_if mclk ();

  // ****************************************
  // Bus decode
  // ****************************************
  wire in_hold = state_q == rsc_pkg::ST_HOLD;
  // Writes are ignored while the system is in reset
  wire supply_wr = sfr_wr && !in_hold && sfr_addr == rsc_pkg::ADDR_SUPPLY_CTRL;
  wire src_wr = sfr_wr && !in_hold && sfr_addr == rsc_pkg::ADDR_RESET_SRC;
  wire [7:0] supply_rd_val = {supply_en_q, supply_above, thresh_q, 5'h00};
  wire [7:0] src_rd_val = {1'b0, flags_q};
  wire [7:0] rd_mux = (sfr_addr == rsc_pkg::ADDR_SUPPLY_CTRL) ? supply_rd_val :
                      (sfr_addr == rsc_pkg::ADDR_RESET_SRC) ? src_rd_val : 8'h00;

  // ****************************************
  // Reset requests
  // ****************************************
  // flash guard condition
  wire flash_any = flash_rd || flash_wr || flash_erase;
  wire flash_guard = supply_en_q && supply_sel_q && thresh_q;
  wire flash_fault = ((flash_wr || flash_erase || table_read) && addr_reserved) ||
                     branch_reserved || (flash_any && security_block) ||
                     (flash_any && !flash_guard);

  assign req[rsc_pkg::SRC_PIN] = !rst_pin_n_in && !rst_pin_oe;
  assign req[rsc_pkg::SRC_POWER] = supply_en_q && supply_sel_q && !supply_above;
  assign req[rsc_pkg::SRC_MCLK] = mclk.timeout;
  assign req[rsc_pkg::SRC_WDOG] = wdog_en_q && wdog_expire && !in_hold;
  assign req[rsc_pkg::SRC_SOFT] = src_wr && sfr_wdata[rsc_pkg::SRC_SOFT];
  assign req[rsc_pkg::SRC_COMP] = comp_en_q && !comp_out;
  assign req[rsc_pkg::SRC_FLASH] = flash_fault && !in_hold;

  wire any_req = |req;
  wire hold_done = in_hold && !any_req && hold_q == HCW'(HOLD_CYCLES - 1);

  // ****************************************
  // Missing clock detector
  // ****************************************
  assign mclk.enable = mclk_en_q;
  assign mclk.clk_level = system_clock_level;

  // Watches the level of the system clock
  rsc_missing_clock u_mclk (
    .clock(clock),
    .sys_rst(sys_rst),
    .mclk(mclk)
  );

  // ****************************************
  // Sequencer next state
  // ****************************************
  always_comb
  begin
    state_d = state_q;
    hold_d = '0;
    cause_d = cause_q;
    unique case (state_q)
      rsc_pkg::ST_RUN:
      begin
        // Enter reset, record the causes seen now
        if (any_req)
        begin
          state_d = rsc_pkg::ST_HOLD;
          cause_d = req;
        end
      end
      rsc_pkg::ST_HOLD:
      begin
        // Keep gathering causes while in reset
        cause_d = cause_q | req;
        if (hold_done)
        begin
          state_d = rsc_pkg::ST_RUN;
        end
        else if (!any_req)
        begin
          hold_d = hold_q + 1'b1;
        end
      end
      default:
      begin
        state_d = rsc_pkg::ST_HOLD;
      end
    endcase
  end

  // ****************************************
  // Sequencer registers
  // ****************************************
  // Power-on enters reset with the power cause
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      state_q <= rsc_pkg::ST_HOLD;
      hold_q <= '0;
      cause_q <= rsc_pkg::CAUSE_POWER;
    end
    else
    begin
      state_q <= state_d;
      hold_q <= hold_d;
      cause_q <= cause_d;
    end
  end

  // ****************************************
  // Reset flags
  // ****************************************
  // flags survive, updated on exit only
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      flags_q <= rsc_pkg::FLAGS_RST;
    end
    // only the causes of this reset remain
    else if (hold_done)
    begin
      flags_q <= cause_q;
    end
  end

  // ****************************************
  // Supply monitor control
  // ****************************************
  // Kept across every reset except power-on
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      supply_en_q <= rsc_pkg::SUPPLY_EN_RST;
      supply_sel_q <= rsc_pkg::SUPPLY_SEL_RST;
      thresh_q <= rsc_pkg::THRESH_SEL_RST;
    end
    else
    begin
      if (supply_wr)
      begin
        supply_en_q <= sfr_wdata[rsc_pkg::SUPPLY_EN_BIT];
      end
      if (supply_wr)
      begin
        thresh_q <= sfr_wdata[rsc_pkg::THRESH_SEL_BIT];
      end
      if (src_wr)
      begin
        supply_sel_q <= sfr_wdata[rsc_pkg::SRC_POWER];
      end
    end
  end

  // ****************************************
  // Source enables
  // ****************************************
  // Cleared by any reset, set by software
  always_ff @(posedge clock)
  begin
    if (sys_rst || in_hold)
    begin
      mclk_en_q <= 1'b0;
      comp_en_q <= 1'b0;
    end
    else if (src_wr)
    begin
      mclk_en_q <= sfr_wdata[rsc_pkg::SRC_MCLK];
      comp_en_q <= sfr_wdata[rsc_pkg::SRC_COMP];
    end
  end

  // ****************************************
  // Watchdog enable and divider
  // ****************************************
  // enabled after any reset
  always_ff @(posedge clock)
  begin
    if (sys_rst || in_hold)
    begin
      wdog_en_q <= 1'b1;
    end
    else if (wdog_disable)
    begin
      wdog_en_q <= 1'b0;
    end
  end

  wire div_wrap = wdog_div_q == rsc_pkg::WDOG_CW'(rsc_pkg::WDOG_DIV - 1);

  always_ff @(posedge clock)
  begin
    if (sys_rst || in_hold || div_wrap)
    begin
      wdog_div_q <= '0;
    end
    else
    begin
      wdog_div_q <= wdog_div_q + 1'b1;
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  // Data appears the cycle after the read strobe
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      rdata_q <= 8'h00;
    end
    else if (sfr_rd)
    begin
      rdata_q <= rd_mux;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign sfr_rdata = rdata_q;
  assign sys_reset = in_hold;
  // pin driven low for power resets only
  assign rst_pin_out = 1'b0;
  assign rst_pin_oe = in_hold && cause_q[rsc_pkg::SRC_POWER];
  assign supply_monitor_enable = supply_en_q;
  assign threshold_select = thresh_q;
  assign wdog_enable = wdog_en_q;
  assign wdog_tick = wdog_en_q && div_wrap && !in_hold;
endmodule

// *** include/rsc_pkg.sv ***
// ****************************************
// Reset source controller constants
// ****************************************
package rsc_pkg;
  // Register addresses on the special function register bus
  localparam logic [7:0] ADDR_SUPPLY_CTRL = 8'hff;
  localparam logic [7:0] ADDR_RESET_SRC = 8'hef;
  // Supply monitor control fields
  localparam int SUPPLY_EN_BIT = 7;
  localparam int SUPPLY_STAT_BIT = 6;
  localparam int THRESH_SEL_BIT = 5;
  // Reset source fields, also the cause vector layout
  localparam int SRC_PIN = 0;
  localparam int SRC_POWER = 1;
  localparam int SRC_MCLK = 2;
  localparam int SRC_WDOG = 3;
  localparam int SRC_SOFT = 4;
  localparam int SRC_COMP = 5;
  localparam int SRC_FLASH = 6;
  localparam int SRC_W = 7;
  // Values after power-on
  localparam logic SUPPLY_EN_RST = 1'b1;
  localparam logic SUPPLY_SEL_RST = 1'b1;
  localparam logic THRESH_SEL_RST = 1'b0;
  localparam logic [SRC_W-1:0] FLAGS_RST = 7'h00;
  localparam logic [SRC_W-1:0] CAUSE_POWER = 7'h02;
  // Timing
  localparam int CLK_HZ = 40_000_000;
  localparam int MCLK_TIMEOUT_NS = 100_000;
  localparam int MCLK_TIMEOUT_CYC = (MCLK_TIMEOUT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int MCLK_CW = 12;
  localparam int WDOG_DIV = 12;
  localparam int WDOG_CW = 4;
  localparam int HOLD_CYC = 4;
  // Sequencer states
  typedef enum logic [1:0]
  {
    ST_RUN = 2'b01,
    ST_HOLD = 2'b10
  } rsc_state_e;
endpackage

// *** include/rsc_mclk_if.sv ***
`timescale 1ns/1ps
// ****************************************
// Missing clock detector link
// ****************************************
interface rsc_mclk_if;
  // Detector armed
  logic enable;
  // Watched clock level
  logic clk_level;
  // One-cycle timeout pulse
  logic timeout;
  modport ctrl (output enable, output clk_level, input timeout);
  modport det (input enable, input clk_level, output timeout);
endinterface

// *** logic/rsc_missing_clock.sv ***
`timescale 1ns/1ps
// ****************************************
// Missing clock one-shot
// ****************************************
module rsc_missing_clock (
  input wire logic clock,
  input wire logic sys_rst,
  rsc_mclk_if.det mclk
);
  // Last seen level of the watched clock
  logic level_q;
  // Cycles since the last level change
  logic [rsc_pkg::MCLK_CW-1:0] quiet_q;
  logic [rsc_pkg::MCLK_CW-1:0] quiet_d;
  // A change of level retriggers the one-shot
  wire edge_seen = mclk.clk_level != level_q;
  wire expired = quiet_q == rsc_pkg::MCLK_CW'(rsc_pkg::MCLK_TIMEOUT_CYC);

  // Count stays at the limit once expired
  assign quiet_d = (edge_seen || !mclk.enable) ? '0 :
                   expired ? quiet_q : quiet_q + 1'b1;
  // Pulse only on reaching the limit
  assign mclk.timeout = mclk.enable && !edge_seen &&
                        (quiet_q == rsc_pkg::MCLK_CW'(rsc_pkg::MCLK_TIMEOUT_CYC - 1));

  // Level and quiet counter
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      level_q <= 1'b0;
      quiet_q <= '0;
    end
    else
    begin
      level_q <= mclk.clk_level;
      quiet_q <= quiet_d;
    end
  end
endmodule

// *** testbench/rsc_props.sv ***
`timescale 1ns/1ps
// **********
// Reset source checker
// **********
module rsc_props #(
  parameter int HOLD_CYCLES = 4
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_rdata,
  input wire logic rst_pin_out,
  input wire logic rst_pin_oe,
  input wire logic rst_pin_n_in,
  input wire logic supply_above,
  input wire logic wdog_expire,
  input wire logic flash_rd,
  input wire logic flash_wr,
  input wire logic flash_erase,
  input wire logic table_read,
  input wire logic addr_reserved,
  input wire logic branch_reserved,
  input wire logic security_block,
  input wire logic sys_reset,
  input wire logic supply_monitor_enable,
  input wire logic threshold_select,
  input wire logic wdog_enable,
  input wire logic wdog_tick
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  // Length of current reset, cycles since last tick
  logic [7:0] run_q;
  logic [3:0] gap_q;
  // Software force write
  wire sw_req = sfr_wr && sfr_addr == rsc_pkg::ADDR_RESET_SRC && sfr_wdata[4] && !sys_reset;
  // Any flash access
  wire any_fl = flash_rd || flash_wr || flash_erase;
  // Access into reserved or secured space
  wire resv = (flash_wr || flash_erase || table_read) && addr_reserved || branch_reserved || any_fl && security_block;
  // Counts reset length and tick spacing
  always_ff @(posedge clock)
  begin
    run_q <= (sys_rst || !sys_reset) ? 8'h00 : run_q + {7'h00, run_q != 8'hff};
    if (sys_rst || sys_reset || !wdog_enable)
      gap_q <= 4'h0;
    else if (wdog_tick)
      gap_q <= 4'h1;
    else if (gap_q != 4'h0)
      gap_q <= gap_q + 4'h1;
  end
  sequence s_sw_req;
    sw_req;
  endsequence
  sequence s_pin_free;
    !rst_pin_oe [*4];
  endsequence
  a_pin_untouched: assert property (s_sw_req |=> s_pin_free)
    else $error("pin driven by software reset");
  a_soft_force: assert property (s_sw_req |=> sys_reset)
    else $error("software reset not taken");
  a_pin_reset: assert property (!rst_pin_n_in && !rst_pin_oe |=> sys_reset)
    else $error("pin low gave no reset");
  a_pin_low: assert property (rst_pin_oe |-> !rst_pin_out)
    else $error("pin driven high");
  a_hold_min: assert property ($fell(sys_reset) |-> run_q >= HOLD_CYCLES)
    else $error("reset released early");
  a_tick_period: assert property (wdog_tick && gap_q != 4'h0 |-> gap_q == 4'hc)
    else $error("watchdog tick spacing wrong");
  a_wdog_reset: assert property (wdog_expire && wdog_enable && !sys_reset |=> sys_reset)
    else $error("watchdog expiry gave no reset");
  a_flash_resv: assert property (resv && !sys_reset |=> sys_reset)
    else $error("reserved access gave no reset");
  a_flash_guard: assert property (any_fl && !threshold_select && !sys_reset |=> sys_reset)
    else $error("unguarded flash access gave no reset");
  a_supply_read: assert property (sfr_rd && !sys_reset && sfr_addr == rsc_pkg::ADDR_SUPPLY_CTRL |=>
    sfr_rdata == {$past(supply_monitor_enable), $past(supply_above), $past(threshold_select), 5'h00})
    else $error("control register read wrong");
  a_thr_keep: assert property (!(sfr_wr && sfr_addr == rsc_pkg::ADDR_SUPPLY_CTRL) |=> $stable(threshold_select))
    else $error("threshold changed without write");
endmodule
bind rsc_reset_source_controller rsc_props #(.HOLD_CYCLES(HOLD_CYCLES)) u_props (
  .clock(clock),
  .sys_rst(sys_rst),
  .sfr_addr(sfr_addr),
  .sfr_wdata(sfr_wdata),
  .sfr_wr(sfr_wr),
  .sfr_rd(sfr_rd),
  .sfr_rdata(sfr_rdata),
  .rst_pin_out(rst_pin_out),
  .rst_pin_oe(rst_pin_oe),
  .rst_pin_n_in(rst_pin_n_in),
  .supply_above(supply_above),
  .wdog_expire(wdog_expire),
  .flash_rd(flash_rd),
  .flash_wr(flash_wr),
  .flash_erase(flash_erase),
  .table_read(table_read),
  .addr_reserved(addr_reserved),
  .branch_reserved(branch_reserved),
  .security_block(security_block),
  .sys_reset(sys_reset),
  .supply_monitor_enable(supply_monitor_enable),
  .threshold_select(threshold_select),
  .wdog_enable(wdog_enable),
  .wdog_tick(wdog_tick)
);

// *** testbench/rsc_pin_model.sv ***
`timescale 1ns/1ps
// **********
// External reset pin with pull-up
// **********
module rsc_pin_model (
  input wire logic rst_pin_out,
  input wire logic rst_pin_oe,
  input wire logic ext_low,
  output logic pin_level
);
  // outside switch pulls low
  // Device drive wins, then the outside switch, else the pull-up
  assign pin_level = rst_pin_oe ? rst_pin_out : !ext_low;
endmodule

// *** testbench/tb.sv ***
`timescale 1ns/1ps
// **********
// Reset source bench
// **********
module tb;
  localparam logic [7:0] A_SRC = rsc_pkg::ADDR_RESET_SRC;
  localparam logic [7:0] A_SUP = rsc_pkg::ADDR_SUPPLY_CTRL;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic ext_low = 1'b0;
  logic supply_above = 1'b1;
  logic comp_out = 1'b1;
  logic system_clock_level = 1'b0;
  logic hold_clk = 1'b0;
  logic wdog_expire = 1'b0;
  logic wdog_disable = 1'b0;
  logic flash_rd = 1'b0;
  logic addr_reserved = 1'b0;
  logic security_block = 1'b0;
  // Flash write, table read, reserved branch, erase
  logic [3:0] fl = 4'h0;
  logic [7:0] sfr_rdata;
  logic rst_pin_out, rst_pin_oe, pin_level;
  logic sys_reset, supply_monitor_enable, threshold_select, wdog_enable, wdog_tick;
  logic [31:0] lfsr_q = 32'h97db0ac8;
  logic [7:0] exp_q[$];
  logic pend_q = 1'b0;
  int num_errors = 0;
  int n_checks = 0;
  always #12.5 clock = ~clock;
  rsc_pin_model pin (.rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe), .ext_low(ext_low), .pin_level(pin_level));
  rsc_reset_source_controller dut (.clock(clock), .sys_rst(sys_rst), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .rst_pin_n_in(pin_level), .rst_pin_out(rst_pin_out),
    .rst_pin_oe(rst_pin_oe), .supply_above(supply_above), .comp_out(comp_out), .system_clock_level(system_clock_level),
    .wdog_expire(wdog_expire), .wdog_disable(wdog_disable), .flash_rd(flash_rd), .flash_wr(fl[3]), .flash_erase(fl[0]),
    .table_read(fl[2]), .addr_reserved(addr_reserved), .branch_reserved(fl[1]), .security_block(security_block),
    .sys_reset(sys_reset), .supply_monitor_enable(supply_monitor_enable), .threshold_select(threshold_select),
    .wdog_enable(wdog_enable), .wdog_tick(wdog_tick));
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // Random watched clock level, frozen for the stuck clock case
  always @(negedge clock)
  begin
    lfsr_q <= lfsr(lfsr_q);
    if (!hold_clk)
      system_clock_level <= lfsr_q[0];
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Read data compared one cycle after its strobe
  always @(posedge clock)
    pend_q <= sfr_rd;
  always @(negedge clock)
    if (pend_q && exp_q.size() > 0)
      check("sfr_rdata", sfr_rdata, exp_q.pop_front());
  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clock);
    sfr_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clock);
    sfr_addr = a;
    sfr_rd = 1'b1;
    exp_q.push_back(e);
    @(negedge clock);
    sfr_rd = 1'b0;
  endtask
  task automatic wait_lvl(input logic lvl, input int lim);
    for (int i = 0; i < lim && sys_reset !== lvl; i++)
      @(negedge clock);
    if (sys_reset !== lvl)
    begin
      num_errors++;
      finish_test();
    end
  endtask
  // Wait for a reset, drop every request, then read the flags
  task automatic cause(input logic [7:0] e, input logic oe);
    wait_lvl(1'b1, 5000);
    check("pin_oe", {7'h00, rst_pin_oe}, {7'h00, oe});
    {supply_above, comp_out, ext_low, wdog_expire, hold_clk} = 5'h18;
    {flash_rd, fl, addr_reserved, security_block} = 7'h00;
    wait_lvl(1'b0, 50);
    rd(A_SRC, e);
  endtask
  task automatic quiet(input int n);
    repeat (n)
    begin
      @(negedge clock);
      check("sys_reset", {7'h00, sys_reset}, 8'h00);
    end
  endtask
  initial
  begin
    repeat (10) @(negedge clock);
    check("sys_reset", {7'h00, sys_reset}, 8'h01);
    sys_rst = 1'b0;
    cause(8'h02, 1'b1);
    check("wdog_enable", {7'h00, wdog_enable}, 8'h01);
    rd(A_SUP, 8'hc0);
    rd(8'h12, 8'h00);
    wr(8'h12, 8'hff);
    quiet(2);
    wr(A_SUP, {3'b101, lfsr_q[4:0]});
    check("supply_monitor_enable", {7'h00, supply_monitor_enable}, 8'h01);
    check("threshold_select", {7'h00, threshold_select}, 8'h01);
    rd(A_SUP, 8'he0);
    wr(A_SUP, 8'h20);
    check("supply_monitor_enable", {7'h00, supply_monitor_enable}, 8'h00);
    supply_above = 1'b0;
    quiet(6);
    rd(A_SUP, 8'h20);
    wr(A_SRC, 8'h00);
    wr(A_SUP, 8'ha0);
    quiet(6);
    wr(A_SRC, 8'h02);
    cause(8'h02, 1'b1);
    wdog_disable = 1'b1;
    @(negedge clock);
    wdog_disable = 1'b0;
    check("wdog_enable", {7'h00, wdog_enable}, 8'h00);
    wdog_expire = 1'b1;
    quiet(2);
    wdog_expire = 1'b0;
    wr(A_SRC, 8'h12);
    cause(8'h10, 1'b0);
    check("wdog_enable", {7'h00, wdog_enable}, 8'h01);
    ext_low = 1'b1;
    cause(8'h01, 1'b0);
    comp_out = 1'b0;
    quiet(4);
    wr(A_SRC, 8'h22);
    cause(8'h20, 1'b0);
    wdog_expire = 1'b1;
    cause(8'h08, 1'b0);
    check("wdog_enable", {7'h00, wdog_enable}, 8'h01);
    flash_rd = 1'b1;
    quiet(2);
    for (int i = 0; i < 4; i++)
    begin
      fl = 4'h8 >> i;
      addr_reserved = i < 2;
      security_block = i == 3;
      cause(8'h40, 1'b0);
    end
    wr(A_SUP, 8'h80);
    flash_rd = 1'b1;
    cause(8'h40, 1'b0);
    wr(A_SRC, 8'h06);
    wr(A_SRC, 8'h02);
    hold_clk = 1'b1;
    quiet(4100);
    wr(A_SRC, 8'h06);
    cause(8'h04, 1'b0);
    finish_test();
  end
endmodule
